// ---- logic/ssf_pkg.sv ----
// Package: register map, field layout and shared types of the serial flag block
//==============================================================================
// Summary of operation
// (RULE1) In buffered operation the transmit-empty flag is 1 while the single transmit buffer is empty, 0 while full.
// (RULE2) Without FIFO or DMA, software clears the transmit-empty flag by reading status with it set, then writing data.
// (RULE3) In buffered operation without DMA a data write is dropped unless status was read before with the transmit-empty flag set.
// (RULE4) With transmit DMA enabled the transmit-empty flag clears when the DMA done pulse arrives, in either operation.
// (RULE5) A write to an idle interface moves to the shifter at once and the flag is set again within two bus cycles.
// (RULE6) In buffered operation a finished shift pulls the queued word into the shifter and sets the flag.
// (RULE7) If nothing is queued when a shift finishes, the flag stays set and nothing moves into the shifter.
// (RULE8) In FIFO operation the transmit-empty flag shows the whole FIFO and is 1 only while the FIFO is empty.
// (RULE9) In FIFO operation without DMA any data write into the FIFO clears the flag, no status read needed.
// (RULE10) In FIFO operation on an idle interface the first word goes to the shifter, a second write clears the flag.
// (RULE11) In FIFO operation queued words follow each finished shift; the flag sets only once the FIFO has drained.
// (RULE12) The mode-fault flag sets on a low select input only with master on, fault detect on, select output off.
// (RULE13) Software clears the mode-fault flag by reading it as 1 and then writing the first control register.
// (RULE14) The receive-match flag reads 1 when the received word equals the match value.
// (RULE15) The match flag sets only once the receive-full flag is 1; software clears it by read-while-set, then write 1.
`default_nettype none

package ssf_pkg;
  //============================================================================
  // Bus geometry and register byte offsets
  localparam int SSF_ADDR_W = 8;
  localparam logic [7:0] SSF_OFF_STATUS = 8'h00;
  localparam logic [7:0] SSF_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] SSF_OFF_CTRL2 = 8'h08;
  localparam logic [7:0] SSF_OFF_DATA = 8'h0C;
  localparam logic [7:0] SSF_OFF_MATCH = 8'h10;

  //============================================================================
  // Field positions
  localparam int SSF_C1_MASTER_BIT = 4;
  localparam int SSF_C1_SELECT_OUTPUT_ENABLE_BIT = 1;
  localparam int SSF_C2_FAULT_EN_BIT = 4;
  localparam int SSF_C2_DMA_EN_BIT = 2;
  localparam int SSF_C2_FIFO_BIT = 0;
  localparam int SSF_ST_MATCH_BIT = 6;

  //============================================================================
  // Reset values and implemented-bit masks
  localparam logic [7:0] SSF_STATUS_RST = 8'h20;
  localparam logic [7:0] SSF_CTRL1_RST = 8'h00;
  localparam logic [7:0] SSF_CTRL2_RST = 8'h00;
  localparam logic [7:0] SSF_CTRL1_MASK = 8'h12;
  localparam logic [7:0] SSF_CTRL2_MASK = 8'h15;

  //============================================================================
  // Timing and bus answers
  localparam int SSF_TXE_SET_CYCLES = 2;
  localparam logic [1:0] SSF_RESP_OKAY = 2'h0;
  localparam logic [1:0] SSF_RESP_SLVERR = 2'h2;

  //============================================================================
  // Types
  typedef enum logic {SSF_IDLE, SSF_SHIFT} ssf_shift_e;

  typedef struct packed {
    logic rx_full;
    logic match;
    logic tx_empty;
    logic mode_fault;
    logic [3:0] rsvd;
  } ssf_status_s;

  typedef struct packed {
    logic sclk;
    logic miso;
    logic ss_n;
  } ssf_pins_s;
endpackage : ssf_pkg

`default_nettype wire

// ---- logic/ssf_spi_status_flags.sv ----
// Module: transmit/receive status flags, transmit queue and shifter behind an AXI4-Lite slave
`default_nettype none

module ssf_spi_status_flags #(
  parameter int DATA_W = 16,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // AXI4-Lite write address and data
  input wire logic [ssf_pkg::SSF_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ssf_pkg::SSF_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link pins
  input wire logic sclk_in,
  input wire logic miso_in,
  input wire logic ss_in_n,
  output logic mosi,
  // Transmit DMA handshake
  input wire logic tx_dma_done,
  output logic tx_dma_request
);
  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam int BC_W = $clog2(DATA_W);

  //============================================================================
  // Elaboration checks
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two of at least 2");
  end
  if (DATA_W < 2 || DATA_W > 16)
  begin : g_bad_width
    $error("DATA_W must lie between 2 and 16");
  end

  //============================================================================
  // State
  ssf_pkg::ssf_status_s status_r;
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic [DATA_W-1:0] match_r;
  logic [DATA_W-1:0] rx_buf_r;
  logic [DATA_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wptr_r;
  logic [PTR_W-1:0] rptr_r;
  logic [CNT_W-1:0] count_r;
  logic [DATA_W-1:0] shift_r;
  logic [BC_W-1:0] bit_cnt_r;
  ssf_pkg::ssf_shift_e state_r;
  logic txe_armed_r;
  logic mode_fault_flag_armed_r;
  logic match_armed_r;
  logic rx_new_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [ssf_pkg::SSF_ADDR_W-1:0] wr_addr_r;
  logic [31:0] wr_data_r;
  logic [3:0] wr_strb_r;
  ssf_pkg::ssf_pins_s sync1_r;
  ssf_pkg::ssf_pins_s sync2_r;
  ssf_pkg::ssf_pins_s sync3_r;
  ssf_pkg::ssf_pins_s pin_st_r;
  ssf_pkg::ssf_pins_s pin_st_d_r;

  //============================================================================
  // Pin synchroniser: a level counts once stages two and three agree
  ssf_pkg::ssf_pins_s pin_raw;
  ssf_pkg::ssf_pins_s pin_st_nxt;
  wire logic sclk_rise;
  wire logic sclk_fall;
  assign pin_raw = {sclk_in, miso_in, ss_in_n};
  assign pin_st_nxt = (sync2_r & ~(sync2_r ^ sync3_r)) | (pin_st_r & (sync2_r ^ sync3_r));
  assign sclk_rise = pin_st_r.sclk & ~pin_st_d_r.sclk;
  assign sclk_fall = ~pin_st_r.sclk & pin_st_d_r.sclk;

  // Select and link clock reset to their idle high: no fake fault, no false edge after reset
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_r <= 3'h5;
      sync2_r <= 3'h5;
      sync3_r <= 3'h5;
      pin_st_r <= 3'h5;
      pin_st_d_r <= 3'h5;
    end
    else
    begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_st_r <= pin_st_nxt;
      pin_st_d_r <= pin_st_r;
    end
  end

  //============================================================================
  // AXI4-Lite handshake decode
  wire logic aw_take;
  wire logic w_take;
  wire logic wr_fire;
  wire logic ar_take;
  wire logic aw_hold_nxt;
  wire logic w_hold_nxt;
  wire logic bvalid_nxt;
  wire logic rvalid_nxt;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign aw_hold_nxt = (aw_hold_r | aw_take) & ~wr_fire;
  assign w_hold_nxt = (w_hold_r | w_take) & ~wr_fire;
  assign bvalid_nxt = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // Register selects by word address
  wire logic wr_hit_status;
  wire logic wr_hit_ctrl1;
  wire logic wr_hit_ctrl2;
  wire logic wr_hit_data;
  wire logic wr_hit_match;
  wire logic wr_mapped;
  wire logic wr_lo;
  assign wr_hit_status = wr_addr_r[7:2] == ssf_pkg::SSF_OFF_STATUS[7:2];
  assign wr_hit_ctrl1 = wr_addr_r[7:2] == ssf_pkg::SSF_OFF_CTRL1[7:2];
  assign wr_hit_ctrl2 = wr_addr_r[7:2] == ssf_pkg::SSF_OFF_CTRL2[7:2];
  assign wr_hit_data = wr_addr_r[7:2] == ssf_pkg::SSF_OFF_DATA[7:2];
  assign wr_hit_match = wr_addr_r[7:2] == ssf_pkg::SSF_OFF_MATCH[7:2];
  assign wr_mapped = wr_hit_status | wr_hit_ctrl1 | wr_hit_ctrl2 | wr_hit_data | wr_hit_match;
  assign wr_lo = wr_fire & wr_strb_r[0];

  wire logic rd_hit_status;
  wire logic rd_hit_ctrl1;
  wire logic rd_hit_ctrl2;
  wire logic rd_hit_data;
  wire logic rd_hit_match;
  wire logic rd_mapped;
  wire logic [31:0] rd_word;
  assign rd_hit_status = s_axi_araddr[7:2] == ssf_pkg::SSF_OFF_STATUS[7:2];
  assign rd_hit_ctrl1 = s_axi_araddr[7:2] == ssf_pkg::SSF_OFF_CTRL1[7:2];
  assign rd_hit_ctrl2 = s_axi_araddr[7:2] == ssf_pkg::SSF_OFF_CTRL2[7:2];
  assign rd_hit_data = s_axi_araddr[7:2] == ssf_pkg::SSF_OFF_DATA[7:2];
  assign rd_hit_match = s_axi_araddr[7:2] == ssf_pkg::SSF_OFF_MATCH[7:2];
  assign rd_mapped = rd_hit_status | rd_hit_ctrl1 | rd_hit_ctrl2 | rd_hit_data | rd_hit_match;
  assign rd_word = rd_hit_status ? {24'h000000, status_r} :
                   rd_hit_ctrl1 ? {24'h000000, ctrl1_r} :
                   rd_hit_ctrl2 ? {24'h000000, ctrl2_r} :
                   rd_hit_data ? {{(32 - DATA_W){1'b0}}, rx_buf_r} :
                   rd_hit_match ? {{(32 - DATA_W){1'b0}}, match_r} : 32'h00000000;

  // Bus channels; one write and one read in flight at a time
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 32'h00000000;
      wr_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      if (aw_take)
        wr_addr_r <= s_axi_awaddr;
      if (w_take)
      begin
        wr_data_r <= s_axi_wdata;
        wr_strb_r <= s_axi_wstrb;
      end
      s_axi_awready <= ~aw_hold_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_hold_nxt & ~bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (wr_fire)
        s_axi_bresp <= wr_mapped ? ssf_pkg::SSF_RESP_OKAY : ssf_pkg::SSF_RESP_SLVERR;
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (ar_take)
      begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? ssf_pkg::SSF_RESP_OKAY : ssf_pkg::SSF_RESP_SLVERR;
      end
    end
  end

  //============================================================================
  // Control fields
  wire logic master_select;
  wire logic select_output_enable;
  wire logic fault_detect_enable;
  wire logic tx_dma_request_enable;
  wire logic fifo_operation_select;
  assign master_select = ctrl1_r[ssf_pkg::SSF_C1_MASTER_BIT];
  assign select_output_enable = ctrl1_r[ssf_pkg::SSF_C1_SELECT_OUTPUT_ENABLE_BIT];
  assign fault_detect_enable = ctrl2_r[ssf_pkg::SSF_C2_FAULT_EN_BIT];
  assign tx_dma_request_enable = ctrl2_r[ssf_pkg::SSF_C2_DMA_EN_BIT];
  assign fifo_operation_select = ctrl2_r[ssf_pkg::SSF_C2_FIFO_BIT];

  //============================================================================
  // Transmit queue: one slot in buffered operation, the full depth in FIFO operation
  wire logic data_wr;
  wire logic tx_accept;
  wire logic tx_load;
  wire logic [CNT_W-1:0] tx_cap;
  wire logic [CNT_W-1:0] count_nxt;
  wire logic txe_set;
  wire logic txe_clr;
  wire logic status_rd;
  assign data_wr = wr_lo & wr_hit_data;
  assign tx_cap = fifo_operation_select ? CNT_W'(FIFO_DEPTH) : CNT_W'(1);
  // DMA writes carry no status read, so the arm is only demanded of software
  assign tx_accept = data_wr & (count_r < tx_cap) &
                     (fifo_operation_select | tx_dma_request_enable | txe_armed_r); // RULE3
  assign tx_load = (state_r == ssf_pkg::SSF_IDLE) & (count_r != '0); // RULE5 RULE6 RULE7 RULE10
  assign count_nxt = count_r + CNT_W'(tx_accept) - CNT_W'(tx_load);
  // Flag rises only when the last queued word leaves for the shifter
  assign txe_set = tx_load & (count_nxt == '0); // RULE1 RULE8 RULE11
  assign txe_clr = tx_dma_request_enable ? tx_dma_done : tx_accept; // RULE4 RULE9 RULE10
  assign status_rd = ar_take & rd_hit_status;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (tx_accept)
        wptr_r <= wptr_r + PTR_W'(1);
      if (tx_load)
        rptr_r <= rptr_r + PTR_W'(1);
      count_r <= count_nxt;
    end
  end

  // Storage needs no reset; a slot is read only after it was written
  always_ff @(posedge mclk)
  begin
    if (tx_accept)
      fifo_mem[wptr_r] <= wr_data_r[DATA_W-1:0];
  end

  //============================================================================
  // Shifter: out on falling link clock, in on rising link clock
  wire logic shift_last;
  wire logic shift_done;
  assign shift_last = bit_cnt_r == BC_W'(DATA_W - 1);
  assign shift_done = (state_r == ssf_pkg::SSF_SHIFT) & sclk_rise & shift_last;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ssf_pkg::SSF_IDLE;
      shift_r <= '0;
      bit_cnt_r <= '0;
      mosi <= 1'b0;
      rx_buf_r <= '0;
    end
    else
    begin
      case (state_r)
        ssf_pkg::SSF_IDLE:
        begin
          if (tx_load)
          begin
            shift_r <= fifo_mem[rptr_r];
            mosi <= fifo_mem[rptr_r][DATA_W-1];
            bit_cnt_r <= '0;
            state_r <= ssf_pkg::SSF_SHIFT;
          end
        end
        ssf_pkg::SSF_SHIFT:
        begin
          if (sclk_rise)
          begin
            shift_r <= {shift_r[DATA_W-2:0], pin_st_r.miso};
            bit_cnt_r <= bit_cnt_r + BC_W'(1);
            if (shift_last)
            begin
              rx_buf_r <= {shift_r[DATA_W-2:0], pin_st_r.miso};
              state_r <= ssf_pkg::SSF_IDLE;
            end
          end
          else if (sclk_fall)
            mosi <= shift_r[DATA_W-1];
        end
        default: state_r <= ssf_pkg::SSF_IDLE;
      endcase
    end
  end

  //============================================================================
  // Flag set and clear terms; every set wins over a clear in the same cycle
  wire logic mode_fault_flag_set;
  wire logic mode_fault_flag_clr;
  wire logic match_set;
  wire logic match_clr;
  wire logic rx_clr;
  assign mode_fault_flag_set = master_select & fault_detect_enable & ~select_output_enable & ~pin_st_r.ss_n; // RULE12
  assign mode_fault_flag_clr = mode_fault_flag_armed_r & wr_lo & wr_hit_ctrl1; // RULE13
  assign match_set = rx_new_r & status_r.rx_full & (rx_buf_r == match_r); // RULE14 RULE15
  assign match_clr = match_armed_r & wr_lo & wr_hit_status & wr_data_r[ssf_pkg::SSF_ST_MATCH_BIT]; // RULE15
  assign rx_clr = ar_take & rd_hit_data;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_r <= ssf_pkg::SSF_STATUS_RST;
      txe_armed_r <= 1'b0;
      mode_fault_flag_armed_r <= 1'b0;
      match_armed_r <= 1'b0;
      rx_new_r <= 1'b0;
      tx_dma_request <= 1'b0;
    end
    else
    begin
      status_r.tx_empty <= txe_set | (status_r.tx_empty & ~txe_clr);
      status_r.mode_fault <= mode_fault_flag_set | (status_r.mode_fault & ~mode_fault_flag_clr);
      status_r.match <= match_set | (status_r.match & ~match_clr);
      status_r.rx_full <= shift_done | (status_r.rx_full & ~rx_clr);
      status_r.rsvd <= 4'h0;
      rx_new_r <= shift_done;
      txe_armed_r <= (status_rd & status_r.tx_empty) | (txe_armed_r & ~tx_accept); // RULE2 RULE3
      mode_fault_flag_armed_r <= (status_rd & status_r.mode_fault) | (mode_fault_flag_armed_r & ~mode_fault_flag_clr);
      match_armed_r <= (status_rd & status_r.match) | (match_armed_r & ~match_clr);
      tx_dma_request <= tx_dma_request_enable & status_r.tx_empty;
    end
  end

  // Software-owned configuration
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl1_r <= ssf_pkg::SSF_CTRL1_RST;
      ctrl2_r <= ssf_pkg::SSF_CTRL2_RST;
      match_r <= '0;
    end
    else if (wr_lo)
    begin
      if (wr_hit_ctrl1)
        ctrl1_r <= wr_data_r[7:0] & ssf_pkg::SSF_CTRL1_MASK;
      if (wr_hit_ctrl2)
        ctrl2_r <= wr_data_r[7:0] & ssf_pkg::SSF_CTRL2_MASK;
      if (wr_hit_match)
        match_r <= wr_data_r[DATA_W-1:0];
    end
  end

  //============================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_idle_write;
    tx_accept && !tx_dma_request_enable && state_r == ssf_pkg::SSF_IDLE && count_r == '0;
  endsequence
  sequence s_quiet_two;
    !tx_accept [*2];
  endsequence

  a_txe_idle_rise: assert property (s_idle_write ##1 s_quiet_two |-> status_r.tx_empty) // RULE5
    else $error("flag not set two cycles after idle write");
  a_txe_write_clear: assert property (tx_accept && !tx_dma_request_enable |=> !status_r.tx_empty) // RULE9
    else $error("accepted write did not clear flag");
  a_write_discard: assert property (data_wr && !fifo_operation_select && !tx_dma_request_enable
                                    && !txe_armed_r |=> $stable(wptr_r)) // RULE3
    else $error("unarmed buffered write was taken");
  a_dma_done_clear: assert property (tx_dma_request_enable && tx_dma_done && !txe_set
                                     |=> !status_r.tx_empty) // RULE4
    else $error("DMA done did not clear flag");
  a_txe_rise_empty: assert property ($rose(status_r.tx_empty) |-> count_r == '0) // RULE8
    else $error("flag rose with words still queued");
  a_no_move_empty: assert property (state_r == ssf_pkg::SSF_IDLE && count_r == '0
                                    |=> state_r == ssf_pkg::SSF_IDLE) // RULE7
    else $error("shifter started with nothing queued");
  a_queue_follow: assert property (shift_done && count_r != '0 |=> ##1 state_r == ssf_pkg::SSF_SHIFT) // RULE6
    else $error("queued word did not follow finished shift");
  a_mode_fault_flag_detect: assert property (master_select && fault_detect_enable && !select_output_enable
                                  && !pin_st_r.ss_n |=> status_r.mode_fault) // RULE12
    else $error("mode fault missed");
  a_mode_fault_flag_gated: assert property (!(master_select && fault_detect_enable && !select_output_enable)
                                 && !status_r.mode_fault |=> !status_r.mode_fault) // RULE12
    else $error("mode fault set while detection off");
  a_match_set: assert property (shift_done ##1 (status_r.rx_full && rx_buf_r == match_r)
                                |=> status_r.match) // RULE14
    else $error("match flag not set");
  a_match_after_full: assert property ($rose(status_r.match) |-> $past(status_r.rx_full)) // RULE15
    else $error("match flag rose without receive full");
endmodule : ssf_spi_status_flags

`default_nettype wire

// ---- testbench/ssf_link_partner.sv ----
// Far-side serial device model: link clock, data in and select
`default_nettype none

module ssf_link_partner (
  // Link pins
  output logic sclk,
  output logic miso,
  output logic ss_n,
  input wire logic mosi
);
  timeunit 1ns;
  timeprecision 100ps;
  //============================================================
  // Clock stands high outside frames, select released
  initial
  begin
    sclk = 1'b1;
    miso = 1'b0;
    ss_n = 1'b1;
  end
  // Select level set by the bench
  task automatic sel(input logic l);
    ss_n = l;
  endtask : sel
  // One word, MSB first; data moves on fall, captured on rise
  task automatic frame(input logic [15:0] w, output logic [15:0] got);
    got = 16'h0000;
    for (int i = 15; i >= 0; i--)
    begin
      #62.5 sclk = 1'b0;
      miso = w[i];
      #62.5 sclk = 1'b1;
      got = {got[14:0], mosi};
    end
    #62.5 miso = ~miso; // Released line shows the inverse, not a held value
  endtask : frame
endmodule : ssf_link_partner

`default_nettype wire

// ---- testbench/test_spi_status_flags.sv ----
// Self-checking bench for the serial status flag block
`default_nettype none

module test_spi_status_flags;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, tx_dma_done = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, mosi, tx_dma_request, sclk_in, miso_in, ss_in_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] wr_resp;
  int err_total = 0;
  int cmp_count = 0;

  ssf_spi_status_flags ssf_spi_status_flags_inst (.mclk(mclk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sclk_in(sclk_in), .miso_in(miso_in), .ss_in_n(ss_in_n), .mosi(mosi),
    .tx_dma_done(tx_dma_done), .tx_dma_request(tx_dma_request));
  ssf_link_partner ssf_link_partner_inst (.sclk(sclk_in), .miso(miso_in), .ss_n(ss_in_n), .mosi(mosi));

  //============================================================
  // Clock, 4 ns period
  always #2 mclk = ~mclk;

  //============================================================
  // Bus tasks; each is entered and left just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b)
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) b = 1'b1;
      wr_resp = bresp;
    end
    bready <= 1'b0;
    // Let an edge pass so a following call never re-raises bready in this step
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic b;
    b = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!b)
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) b = 1'b1;
      d = rdata;
      r = rresp;
    end
    rready <= 1'b0;
    @(posedge mclk);
  endtask : rd
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Status bit compare; the read itself arms the clear sequences
  task automatic sb(input int b, input logic e);
    logic [31:0] d;
    logic [1:0] r;
    rd(ssf_pkg::SSF_OFF_STATUS, d, r);
    chk({31'h0, d[b]}, {31'h0, e});
  endtask : sb
  // Full word over the link, then compare shifted-out word and received word
  task automatic xfer(input logic [15:0] w, input logic [15:0] m);
    logic [15:0] got;
    logic [31:0] d;
    logic [1:0] r;
    ssf_link_partner_inst.frame(w, got);
    repeat (16) @(posedge mclk);
    chk({16'h0, got}, {16'h0, m});
    rd(ssf_pkg::SSF_OFF_DATA, d, r);
    chk(d, {16'h0, w});
  endtask : xfer

  //============================================================
  // Scenarios
  task automatic t_buffered();
    logic [31:0] d;
    logic [1:0] r;
    wr(ssf_pkg::SSF_OFF_DATA, 32'h1111);
    chk({30'h0, wr_resp}, {30'h0, ssf_pkg::SSF_RESP_OKAY});
    rd(ssf_pkg::SSF_OFF_STATUS, d, r);
    chk(d, {24'h0, ssf_pkg::SSF_STATUS_RST});
    wr(ssf_pkg::SSF_OFF_DATA, 32'hA55A);
    sb(5, 1'b1);
    wr(ssf_pkg::SSF_OFF_DATA, 32'h3C3C);
    sb(5, 1'b0);
    wr(ssf_pkg::SSF_OFF_DATA, 32'h7777);
    xfer(16'h0F0F, 16'hA55A);
    sb(5, 1'b1);
    xfer(16'h00FF, 16'h3C3C);
    sb(5, 1'b1);
    rd(8'h14, d, r);
    chk({30'h0, r}, {30'h0, ssf_pkg::SSF_RESP_SLVERR});
    chk(d, 32'h0);
    wr(8'h14, 32'h0);
    chk({30'h0, wr_resp}, {30'h0, ssf_pkg::SSF_RESP_SLVERR});
  endtask : t_buffered
  task automatic t_fifo();
    wr(ssf_pkg::SSF_OFF_CTRL2, 32'h01);
    wr(ssf_pkg::SSF_OFF_DATA, 32'h1001);
    sb(5, 1'b1);
    wr(ssf_pkg::SSF_OFF_DATA, 32'h2002);
    sb(5, 1'b0);
    wr(ssf_pkg::SSF_OFF_DATA, 32'h3003);
    xfer(16'h1234, 16'h1001);
    sb(5, 1'b0);
    xfer(16'h4321, 16'h2002);
    sb(5, 1'b1);
    xfer(16'h5A5A, 16'h3003);
    wr(ssf_pkg::SSF_OFF_CTRL2, 32'h00);
  endtask : t_fifo
  task automatic t_dma();
    wr(ssf_pkg::SSF_OFF_CTRL2, 32'h04);
    chk({31'h0, tx_dma_request}, 32'h1);
    wr(ssf_pkg::SSF_OFF_DATA, 32'h4004);
    wr(ssf_pkg::SSF_OFF_DATA, 32'h5005);
    tx_dma_done <= 1'b1;
    @(posedge mclk);
    tx_dma_done <= 1'b0;
    sb(5, 1'b0);
    chk({31'h0, tx_dma_request}, 32'h0);
    xfer(16'h6006, 16'h4004);
    xfer(16'h7007, 16'h5005);
    wr(ssf_pkg::SSF_OFF_CTRL2, 32'h00);
  endtask : t_dma
  task automatic t_fault();
    wr(ssf_pkg::SSF_OFF_CTRL2, 32'h10);
    wr(ssf_pkg::SSF_OFF_CTRL1, 32'h12);
    ssf_link_partner_inst.sel(1'b0);
    repeat (8) @(posedge mclk);
    sb(4, 1'b0);
    wr(ssf_pkg::SSF_OFF_CTRL1, 32'h10);
    repeat (8) @(posedge mclk);
    sb(4, 1'b1);
    ssf_link_partner_inst.sel(1'b1);
    repeat (8) @(posedge mclk);
    wr(ssf_pkg::SSF_OFF_CTRL1, 32'h10);
    sb(4, 1'b0);
    wr(ssf_pkg::SSF_OFF_CTRL2, 32'h00);
  endtask : t_fault
  task automatic t_match();
    logic [15:0] got;
    wr(ssf_pkg::SSF_OFF_MATCH, 32'hC3A5);
    // The shifter only runs with a word loaded, so queue one first
    sb(5, 1'b1);
    wr(ssf_pkg::SSF_OFF_DATA, 32'h0F0F);
    ssf_link_partner_inst.frame(16'hC3A5, got);
    repeat (16) @(posedge mclk);
    chk({16'h0, got}, 32'h0F0F);
    sb(7, 1'b1);
    sb(6, 1'b1);
    wr(ssf_pkg::SSF_OFF_STATUS, 32'h40);
    sb(6, 1'b0);
  endtask : t_match

  //============================================================
  // Verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Watchdog well beyond about eight link frames
  initial
  begin
    #200000;
    err_total++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    t_buffered();
    t_fifo();
    t_dma();
    t_fault();
    t_match();
    complete_run();
  end
endmodule : test_spi_status_flags

`default_nettype wire
